// ==== verilog/cgs_master.sv ====
`timescale 1ns/1ps
`include "cgs_defs.svh"
module cgs_master
	import cgs_pkg::*;
#(
	parameter int QTR_CYC = `CGS_QTR_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	cgs_if.master           bus,
	input  wire logic       compat_en,
	input  wire logic       req_valid,
	output logic            req_ready,
	input  wire cgs_op_type req_op,
	input  wire logic [6:0] req_index,
	input  wire logic [7:0] req_len,
	input  wire logic [7:0] wr_data,
	output logic            wr_next,
	output logic [7:0]      rd_data,
	output logic            rd_valid,
	output logic            done,
	output logic            nack_err
);
	cgs_mst_phase_type ph_r;
	cgs_op_type        op_r;
	logic [15:0]       div_r;
	logic              tick;
	logic [1:0]        q_r;
	logic [3:0]        bitn_r;
	logic [7:0]        sh_r;
	logic [7:0]        left_r;
	logic [6:0]        idx_r;
	logic              ack_ok_r;
	logic              scl_oe_r;
	logic              sda_oe_r;
	logic              is_byte;
	logic              is_rd;
	logic              last_rd;

	assign tick      = (div_r == 16'(QTR_CYC - 1));
	assign req_ready = (ph_r == CGS_P_IDLE);
	assign is_rd     = (ph_r == CGS_P_RCNT) || (ph_r == CGS_P_RD);
	assign last_rd   = (ph_r == CGS_P_RD) && (left_r <= 8'h01);
	assign is_byte   = !(ph_r inside {CGS_P_IDLE, CGS_P_START, CGS_P_SR, CGS_P_STOP});
	assign bus.m_scl_o  = 1'b0;
	assign bus.m_sda_o  = 1'b0;
	assign bus.m_scl_oe = scl_oe_r;
	assign bus.m_sda_oe = sda_oe_r;

	// Quarter-bit enable; free running so every bit phase has equal length
	always_ff @(posedge sys_clk) begin
		if (!nrst || tick) begin
			div_r <= 16'h0000;
		end else begin
			div_r <= div_r + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ph_r     <= CGS_P_IDLE;
			op_r     <= CGS_OP_BYTE_WR;
			q_r      <= 2'h0;
			bitn_r   <= 4'h0;
			sh_r     <= 8'h00;
			left_r   <= 8'h00;
			idx_r    <= 7'h00;
			ack_ok_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
			wr_next  <= 1'b0;
			done     <= 1'b0;
			nack_err <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			wr_next  <= 1'b0;
			done     <= 1'b0;
			if (ph_r == CGS_P_IDLE) begin
				if (req_valid) begin
					ph_r     <= CGS_P_START;
					op_r     <= req_op;
					idx_r    <= req_index;
					left_r   <= (req_op inside {CGS_OP_BYTE_WR, CGS_OP_BYTE_RD}) ? 8'h01 : req_len;
					q_r      <= 2'h0;
					bitn_r   <= 4'h0;
					nack_err <= 1'b0;
				end
			end else if (tick) begin
				q_r <= q_r + 2'h1;
				unique case (q_r)
					2'h0: begin
						if (ph_r == CGS_P_START || ph_r == CGS_P_SR) begin
							sda_oe_r <= 1'b0;
						end else if (ph_r == CGS_P_STOP) begin
							sda_oe_r <= 1'b1;
						end else if (bitn_r < 4'h8) begin
							sda_oe_r <= is_rd ? 1'b0 : ~sh_r[7];
						end else begin
							sda_oe_r <= is_rd & ~last_rd;
						end
					end
					2'h1: scl_oe_r <= 1'b0;
					2'h2: begin
						if (ph_r == CGS_P_START || ph_r == CGS_P_SR) begin
							sda_oe_r <= 1'b1;
						end else if (ph_r == CGS_P_STOP) begin
							sda_oe_r <= 1'b0;
						end else if (bitn_r < 4'h8) begin
							sh_r <= {sh_r[6:0], bus.sda};
						end else begin
							ack_ok_r <= ~bus.sda;
						end
					end
					2'h3: begin
						if (ph_r != CGS_P_STOP) begin
							scl_oe_r <= 1'b1;
						end
						if (is_byte && bitn_r < 4'h8) begin
							bitn_r <= bitn_r + 4'h1;
						end else begin
							bitn_r <= 4'h0;
							// A refused written byte aborts with a stop
							if (is_byte && !is_rd && !ack_ok_r) begin
								ph_r     <= CGS_P_STOP;
								nack_err <= 1'b1;
							end else begin
								unique case (ph_r)
									CGS_P_START: begin
										ph_r <= CGS_P_AW;
										sh_r <= `CGS_ADDR_BYTE;
									end
									CGS_P_AW: begin
										ph_r <= CGS_P_CMD;
										sh_r <= (op_r inside {CGS_OP_BYTE_WR, CGS_OP_BYTE_RD}) ?
											{1'b1, idx_r} : 8'h00;
									end
									CGS_P_CMD: begin
										if (op_r == CGS_OP_BYTE_RD || op_r == CGS_OP_BLK_RD) begin
											ph_r <= CGS_P_SR;
										end else if (op_r == CGS_OP_BLK_WR && !compat_en) begin
											ph_r <= CGS_P_CNT;
											sh_r <= left_r;
										end else begin
											ph_r    <= CGS_P_WD;
											sh_r    <= wr_data;
											wr_next <= 1'b1;
										end
									end
									CGS_P_CNT: begin
										ph_r    <= CGS_P_WD;
										sh_r    <= wr_data;
										wr_next <= 1'b1;
									end
									CGS_P_WD: begin
										left_r <= left_r - 8'h01;
										if (left_r <= 8'h01) begin
											ph_r <= CGS_P_STOP;
										end else begin
											sh_r    <= wr_data;
											wr_next <= 1'b1;
										end
									end
									CGS_P_SR: begin
										ph_r <= CGS_P_AR;
										sh_r <= `CGS_ADDR_BYTE | 8'h01;
									end
									CGS_P_AR: ph_r <= (op_r == CGS_OP_BLK_RD) ? CGS_P_RCNT : CGS_P_RD;
									CGS_P_RCNT: ph_r <= CGS_P_RD;
									CGS_P_RD: begin
										rd_data  <= sh_r;
										rd_valid <= 1'b1;
										left_r   <= left_r - 8'h01;
										if (left_r <= 8'h01) begin
											ph_r <= CGS_P_STOP;
										end
									end
									CGS_P_STOP: begin
										ph_r <= CGS_P_IDLE;
										done <= 1'b1;
									end
									default: ph_r <= CGS_P_IDLE;
								endcase
							end
						end
					end
				endcase
			end
		end
	end
endmodule // cgs_master

// ==== verilog/cgs_defs.svh ====
`ifndef CGS_DEFS_SVH
`define CGS_DEFS_SVH

// Own bus address as the full 8-bit address byte, direction bit low
`define CGS_ADDR_BYTE     8'hD2
// Command code layout
`define CGS_CMD_SINGLE    7
// Control byte offsets and count
`define CGS_OFS_CTL0      7'h00
`define CGS_OFS_CTL1      7'h01
`define CGS_OFS_CTL2      7'h02
`define CGS_NUM_REGS      8'h03
// Power-up values
`define CGS_CTL0_RST      8'hFF
`define CGS_CTL1_RST      8'hF6
`define CGS_CTL2_RST      8'hFF
// Byte 0 bit that always reads as one
`define CGS_CTL0_FIXED    8'h01
// Field positions in control byte 1
`define CGS_C1_FREE0      7
`define CGS_C1_DOT        6
`define CGS_C1_USB        5
`define CGS_C1_XREF       4
`define CGS_C1_SPRD_SEL   3
`define CGS_C1_SPRD_EN    0
// Master timing: one quarter of a serial clock period at 100 kHz
`define CGS_CLK_NS        40
`define CGS_QTR_NS        2500
`define CGS_QTR_CYC       ((`CGS_QTR_NS + `CGS_CLK_NS - 1) / `CGS_CLK_NS)

`endif

// ==== verilog/cgs_pkg.sv ====
package cgs_pkg;

	typedef enum logic [1:0] {
		CGS_OP_BYTE_WR,
		CGS_OP_BYTE_RD,
		CGS_OP_BLK_WR,
		CGS_OP_BLK_RD
	} cgs_op_type;

	typedef enum logic [2:0] {
		CGS_S_IDLE,
		CGS_S_ADDR,
		CGS_S_CMD,
		CGS_S_CNT,
		CGS_S_WDATA,
		CGS_S_RCNT,
		CGS_S_RDATA
	} cgs_slv_state_type;

	typedef enum logic [3:0] {
		CGS_P_IDLE,
		CGS_P_START,
		CGS_P_AW,
		CGS_P_CMD,
		CGS_P_CNT,
		CGS_P_WD,
		CGS_P_SR,
		CGS_P_AR,
		CGS_P_RCNT,
		CGS_P_RD,
		CGS_P_STOP
	} cgs_mst_phase_type;

endpackage

// ==== verilog/cgs_if.sv ====
`timescale 1ns/1ps
// Open-drain wire pair; a set enable pulls the line to the driven level
interface cgs_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	assign scl = m_scl_oe ? m_scl_o : 1'b1;
	assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

	modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
	modport slave  (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

// ==== verilog/cgs_bus_edges.sv ====
`timescale 1ns/1ps
module cgs_bus_edges (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      start_det,
	output logic      stop_det
);
	logic scl_r;
	logic sda_r;

	// Idle lines are high, so reset to high to avoid a false edge
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
		end else begin
			scl_r <= scl;
			sda_r <= sda;
		end
	end

	assign scl_rise  = scl & ~scl_r;
	assign scl_fall  = ~scl & scl_r;
	assign start_det = scl & scl_r & sda_r & ~sda;
	assign stop_det  = scl & scl_r & ~sda_r & sda;
endmodule // cgs_bus_edges

// ==== verilog/cgs_slave.sv ====
`timescale 1ns/1ps
`include "cgs_defs.svh"
module cgs_slave
	import cgs_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	cgs_if.slave            bus,
	input  wire logic       compat_en,
	output logic            shared_debug_ref_pair_en,
	output logic [5:0]      serial_ref_diff_pair_en,
	output logic [2:0]      free_running_bus_clock_en,
	output logic [5:0]      stoppable_bus_clock_en,
	output logic            display_dot_pair_en,
	output logic            usb_clk_en,
	output logic            xtal_ref_en,
	output logic [1:0]      cpu_pair_en,
	output logic            spread_center,
	output logic            spread_en
);
	cgs_slv_state_type st_r;
	logic [3:0]        cnt_r;
	logic [7:0]        sh_r;
	logic [7:0]        tx_r;
	logic [6:0]        idx_r;
	logic              blk_r;
	logic              oe_r;
	logic [7:0]        ctl0_r;
	logic [7:0]        ctl1_r;
	logic [7:0]        ctl2_r;
	logic [7:0]        rd_cur;
	logic [7:0]        rd_nxt;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_det;
	logic              stop_det;
	logic              tx_st;
	logic              wr_stb;
	logic [6:0]        idx_inc;

	cgs_bus_edges u_cgs_bus_edges (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.scl       (bus.scl),
		.sda       (bus.sda),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	assign tx_st        = (st_r == CGS_S_RCNT) || (st_r == CGS_S_RDATA);
	assign idx_inc      = idx_r + 7'h01;
	assign wr_stb       = (st_r == CGS_S_WDATA) && scl_fall && (cnt_r == 4'h7);
	assign bus.s_sda_o  = 1'b0;
	assign bus.s_sda_oe = oe_r;

	// Unmapped indexes read as zero
	always_comb begin
		unique case (idx_r)
			`CGS_OFS_CTL0: rd_cur = ctl0_r;
			`CGS_OFS_CTL1: rd_cur = ctl1_r;
			`CGS_OFS_CTL2: rd_cur = ctl2_r;
			default:       rd_cur = 8'h00;
		endcase
		unique case (idx_inc)
			`CGS_OFS_CTL0: rd_nxt = ctl0_r;
			`CGS_OFS_CTL1: rd_nxt = ctl1_r;
			`CGS_OFS_CTL2: rd_nxt = ctl2_r;
			default:       rd_nxt = 8'h00;
		endcase
	end

	// Counter starts at F after a start so the first SCL fall wraps it to 0
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_r  <= CGS_S_IDLE;
			cnt_r <= 4'hF;
			sh_r  <= 8'h00;
			tx_r  <= 8'h00;
			idx_r <= 7'h00;
			blk_r <= 1'b0;
			oe_r  <= 1'b0;
		end else if (start_det) begin
			st_r  <= CGS_S_ADDR;
			cnt_r <= 4'hF;
			oe_r  <= 1'b0;
		end else if (stop_det) begin
			st_r <= CGS_S_IDLE;
			oe_r <= 1'b0;
		end else if (st_r != CGS_S_IDLE) begin
			if (scl_rise && cnt_r < 4'h8) begin
				sh_r <= {sh_r[6:0], bus.sda};
			end
			if (scl_rise && cnt_r == 4'h8 && tx_st && bus.sda) begin
				st_r <= CGS_S_IDLE;
			end
			if (scl_fall) begin
				cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
				if (tx_st && cnt_r < 4'h7) begin
					oe_r <= ~tx_r[6];
					tx_r <= {tx_r[6:0], 1'b0};
				end else if (tx_st && cnt_r == 4'h7) begin
					// Release for the master's ack and stage the next byte
					oe_r <= 1'b0;
					if (st_r == CGS_S_RCNT) begin
						st_r <= CGS_S_RDATA;
						tx_r <= rd_cur;
					end else begin
						idx_r <= idx_inc;
						tx_r  <= rd_nxt;
					end
				end else if (cnt_r == 4'h8) begin
					oe_r <= tx_st ? ~tx_r[7] : 1'b0;
				end else if (cnt_r == 4'h7) begin
					unique case (st_r)
						CGS_S_ADDR: begin
							if (sh_r[7:1] == 7'(`CGS_ADDR_BYTE >> 1)) begin
								oe_r <= 1'b1;
								if (sh_r[0]) begin
									st_r <= blk_r ? CGS_S_RCNT : CGS_S_RDATA;
									tx_r <= blk_r ? `CGS_NUM_REGS : rd_cur;
								end else begin
									st_r <= CGS_S_CMD;
								end
							end else begin
								st_r <= CGS_S_IDLE;
								oe_r <= 1'b0;
							end
						end
						CGS_S_CMD: begin
							oe_r  <= 1'b1;
							blk_r <= ~sh_r[`CGS_CMD_SINGLE];
							idx_r <= sh_r[`CGS_CMD_SINGLE] ? sh_r[6:0] : 7'h00;
							if (sh_r[`CGS_CMD_SINGLE] || compat_en) begin
								st_r <= CGS_S_WDATA;
							end else begin
								st_r <= CGS_S_CNT;
							end
						end
						CGS_S_CNT: begin
							oe_r <= 1'b1;
							st_r <= CGS_S_WDATA;
						end
						CGS_S_WDATA: begin
							oe_r  <= 1'b1;
							idx_r <= idx_inc;
						end
						default: oe_r <= 1'b0;
					endcase
				end
			end
		end
	end

	// Writes to unmapped indexes are acked and dropped
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctl0_r <= `CGS_CTL0_RST;
			ctl1_r <= `CGS_CTL1_RST;
			ctl2_r <= `CGS_CTL2_RST;
		end else if (wr_stb) begin
			unique case (idx_r)
				`CGS_OFS_CTL0: ctl0_r <= sh_r | `CGS_CTL0_FIXED;
				`CGS_OFS_CTL1: ctl1_r <= sh_r;
				`CGS_OFS_CTL2: ctl2_r <= sh_r;
				default: ;
			endcase
		end
	end

	// Enables are high-active; a low bit floats or stops the output
	assign shared_debug_ref_pair_en  = ctl0_r[7];
	assign serial_ref_diff_pair_en   = ctl0_r[6:1];
	assign free_running_bus_clock_en = {ctl2_r[1:0], ctl1_r[`CGS_C1_FREE0]};
	assign stoppable_bus_clock_en    = ctl2_r[7:2];
	assign display_dot_pair_en       = ctl1_r[`CGS_C1_DOT];
	assign usb_clk_en                = ctl1_r[`CGS_C1_USB];
	assign xtal_ref_en               = ctl1_r[`CGS_C1_XREF];
	assign cpu_pair_en               = ctl1_r[2:1];
	assign spread_center             = ctl1_r[`CGS_C1_SPRD_SEL];
	assign spread_en                 = ctl1_r[`CGS_C1_SPRD_EN];
endmodule // cgs_slave

// ==== verification/cgs_link_chk.sv ====
`timescale 1ns/1ps
module cgs_link_chk (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic m_scl_o,
	input wire logic m_scl_oe,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_cnt;
	wire        scl_up = scl && !scl_q;
	wire        start_seen = scl && scl_q && sda_q && !sda;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// Idle-high history so that reset release never looks like a start
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// Counts SCL rises since the last start; saturates past the address byte
	always_ff @(posedge sys_clk) begin
		if (!nrst || start_seen)
			bit_cnt <= 4'h0;
		else if (scl_up && bit_cnt != 4'hF)
			bit_cnt <= bit_cnt + 4'h1;
	end

	property p_od_slave; s_sda_oe |-> !s_sda_o; endproperty
	property p_od_mscl; m_scl_oe |-> !m_scl_o; endproperty
	property p_od_msda; m_sda_oe |-> !m_sda_o; endproperty
	property p_rst_release;
		disable iff (1'b0) !nrst |=> !s_sda_oe && !m_sda_oe && !m_scl_oe;
	endproperty
	property p_idle_after_rst; $rose(nrst) |-> (!s_sda_oe && !m_scl_oe) [*4]; endproperty
	property p_slv_chg_low; !$stable(s_sda_oe) |-> !scl && !$past(scl); endproperty
	property p_addr_silent; scl_up && bit_cnt < 4'h8 |-> !s_sda_oe; endproperty
	property p_addr_ack; scl_up && bit_cnt == 4'h8 |-> s_sda_oe && !sda; endproperty

	a_od_slave: assert property (p_od_slave) else $error("slave drives data high");
	a_od_mscl: assert property (p_od_mscl) else $error("master drives clock high");
	a_od_msda: assert property (p_od_msda) else $error("master drives data high");
	a_rst_release: assert property (p_rst_release) else $error("lines held in reset");
	a_idle_after_rst: assert property (p_idle_after_rst) else $error("bus busy after reset");
	a_slv_chg_low: assert property (p_slv_chg_low) else $error("slave moved data, clock high");
	a_addr_silent: assert property (p_addr_silent) else $error("slave drove in address");
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

	c_start: cover property (start_seen);
	c_ack: cover property (scl_up && bit_cnt == 4'h8 && s_sda_oe);
	c_stop: cover property (scl && scl_q && !sda_q && sda);
endmodule // cgs_link_chk

// ==== verification/tb_clock_gen_serial_config_port.sv ====
`timescale 1ns/1ps
module tb_clock_gen_serial_config_port
	import cgs_pkg::*;
;
	localparam int          LIMIT = 60000;
	localparam logic [31:0] WV    = 32'h0009_5A77;
	logic       sys_clk;
	logic       nrst;
	logic       compat_en;
	logic       req_valid;
	cgs_op_type req_op;
	logic [6:0] req_index;
	logic [7:0] req_len;
	logic [7:0] wr_data;
	logic       req_ready;
	logic       wr_next;
	logic [7:0] rd_data;
	logic       rd_valid;
	logic       done;
	logic       nack_err;
	logic       dbg_en;
	logic [5:0] ref_en;
	logic [2:0] free_en;
	logic [5:0] stop_en;
	logic       dot_en;
	logic       usb_en;
	logic       xref_en;
	logic [1:0] cpu_en;
	logic       sp_center;
	logic       sp_en;
	logic [7:0] wq [0:3];
	logic [7:0] rq [0:3];
	int         wp = 0;
	int         rp = 0;
	int         cyc = 0;
	int         err_count = 0;
	int         checked = 0;

	cgs_if u_cgs_if ();

	// Short quarter period keeps each byte near 150 clocks
	cgs_master #(.QTR_CYC(4)) u_cgs_master (
		.sys_clk(sys_clk), .nrst(nrst), .bus(u_cgs_if), .compat_en(compat_en),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
		.req_index(req_index), .req_len(req_len), .wr_data(wr_data), .wr_next(wr_next),
		.rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack_err(nack_err)
	);

	cgs_slave u_cgs_slave (
		.sys_clk(sys_clk), .nrst(nrst), .bus(u_cgs_if), .compat_en(compat_en),
		.shared_debug_ref_pair_en(dbg_en), .serial_ref_diff_pair_en(ref_en),
		.free_running_bus_clock_en(free_en), .stoppable_bus_clock_en(stop_en),
		.display_dot_pair_en(dot_en), .usb_clk_en(usb_en), .xtal_ref_en(xref_en),
		.cpu_pair_en(cpu_en), .spread_center(sp_center), .spread_en(sp_en)
	);

	cgs_link_chk u_cgs_link_chk (
		.sys_clk(sys_clk), .nrst(nrst),
		.m_scl_o(u_cgs_if.m_scl_o), .m_scl_oe(u_cgs_if.m_scl_oe),
		.m_sda_o(u_cgs_if.m_sda_o), .m_sda_oe(u_cgs_if.m_sda_oe),
		.s_sda_o(u_cgs_if.s_sda_o), .s_sda_oe(u_cgs_if.s_sda_oe),
		.scl(u_cgs_if.scl), .sda(u_cgs_if.sda)
	);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Next write byte is staged as soon as the master takes one
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (wr_next) begin
			wp <= wp + 1;
			wr_data <= wq[(wp + 1) % 4];
		end
		if (rd_valid) begin
			rq[rp % 4] <= rd_data;
			rp <= rp + 1;
		end
		if (cyc == LIMIT) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input cgs_op_type op, input logic [6:0] idx, input logic [7:0] len);
		int n;
		n = 0;
		@(posedge sys_clk);
		while (req_ready !== 1'b1) @(posedge sys_clk);
		wp <= 0;
		rp <= 0;
		wr_data <= wq[0];
		req_op <= op;
		req_index <= idx;
		req_len <= len;
		req_valid <= 1'b1;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		while (done !== 1'b1 && n < 4000) begin
			@(posedge sys_clk);
			n++;
		end
		check(8'(n < 4000), 8'h01);
		check({7'h00, nack_err}, 8'h00);
	endtask

	// Byte 0 bit 0 has no pin; it is seen only through read-back
	function automatic logic [23:0] outs();
		return {dbg_en, ref_en, 1'b1, free_en[0], dot_en, usb_en, xref_en, sp_center,
			cpu_en, sp_en, stop_en, free_en[2:1]};
	endfunction

	task automatic regs_are(input logic [23:0] e);
		logic [23:0] o;
		o = outs();
		for (int i = 0; i < 3; i++) begin
			check(o[23-8*i -: 8], e[23-8*i -: 8]);
			xfer(CGS_OP_BYTE_RD, 7'(i), 8'h01);
			check(rq[0], e[23-8*i -: 8]);
		end
	endtask

	initial begin
		nrst = 1'b0;
		compat_en = 1'b0;
		req_valid = 1'b0;
		req_op = CGS_OP_BYTE_WR;
		req_index = 7'h00;
		req_len = 8'h00;
		wr_data = 8'h00;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		// Traffic here is set-up only, never power management while running
		regs_are(24'hFF_F6_FF);
		$display("test power-up values done");
		for (int i = 0; i < 4; i++) begin
			wq[0] = WV[31-8*i -: 8];
			xfer(CGS_OP_BYTE_WR, 7'(i), 8'h01);
		end
		xfer(CGS_OP_BYTE_RD, 7'h03, 8'h01);
		check(rq[0], 8'h00);
		regs_are(24'h01_09_5A);
		$display("test byte writes done");
		wq = '{8'hA5, 8'h3C, 8'hC3, 8'h00};
		xfer(CGS_OP_BLK_WR, 7'h00, 8'h03);
		regs_are(24'hA5_3C_C3);
		$display("test block write done");
		compat_en <= 1'b1;
		wq = '{8'h0E, 8'hF0, 8'h81, 8'h00};
		xfer(CGS_OP_BLK_WR, 7'h00, 8'h03);
		compat_en <= 1'b0;
		regs_are(24'h0F_F0_81);
		$display("test block write without count done");
		xfer(CGS_OP_BLK_RD, 7'h00, 8'h03);
		check(8'(rp), 8'h03);
		for (int i = 0; i < 3; i++)
			check(rq[i], 8'(24'h0F_F0_81 >> (16 - 8*i)));
		xfer(CGS_OP_BLK_RD, 7'h00, 8'h01);
		check(8'(rp), 8'h01);
		check(rq[0], 8'h0F);
		$display("test block read done");
		end_of_test();
	end
endmodule // tb_clock_gen_serial_config_port
